// file: design/sps_cfg.svh
// What this block does
// - Register 1 shows the bridge A level in bits 0-4, bridge B in 5-9.
// - Register 1 bits 10-12 pick the full-scale current range.
// - A bridge needing a new level gets the chosen profile entry copied in.
// - Nine 5-bit profile entries spread over registers 2 to 6.
// - Keep-outputs clear: overvoltage floats the bridges and flags supply high.
// - Keep-outputs set: overvoltage only flags supply high.
// - PWM pin carries bridge A PWM unless disabled, then floats.
// - Stall threshold is assembled from register 3, 4 and 5 bits.
// - Stall threshold is the compare value of the PWM active-time counter.
// - Register 6 bits 5 and 6 are read-only open-load flags.
// - Reference fault is zero only while reference current is in range.
// - Register 6 bit 8 is the read-only motor blocked flag.
// - Register 6 bit 9 selects 20 kHz when set, 30 kHz when clear.
// - Register 6 bit 10 selects 2.5 us glitch filter, else 1.5 us.
// - Mirror bit puts the blocked flag on the PWM pin instead.
// - Writing the register 6 clear bit zeroes its read-only flags, except any whose cause is present that cycle.
// - Frame's first three bits address; commit only with exactly 16 clocks.
// - Blocked flag sets when summed rise time in a quadrant is under threshold.
// - Open-load and reference flags join the fault level shown at frame start.
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH

`define SPS_REG_LEVELS 3'h1
`define SPS_REG_PROF01 3'h2
`define SPS_REG_PROF23 3'h3
`define SPS_REG_PROF45 3'h4
`define SPS_REG_PROF67 3'h5
`define SPS_REG_PROF8 3'h6

`define SPS_FRAME_BITS 5'h10
`define SPS_CNT_SAT 5'h11
`define SPS_ADDR_MSB 15
`define SPS_ADDR_LSB 13
`define SPS_FS_MSB 12
`define SPS_FS_LSB 10
`define SPS_HI_MSB 12
`define SPS_HI_LSB 8
`define SPS_LO_MSB 4
`define SPS_LO_LSB 0
`define SPS_R2_KEEP 7
`define SPS_R2_TEST_MSB 6
`define SPS_R2_TEST_LSB 5
`define SPS_R3_THR_MSB 7
`define SPS_R3_THR_LSB 6
`define SPS_R3_PWMDIS 5
`define SPS_R45_THR_MSB 7
`define SPS_R45_THR_LSB 5
`define SPS_R6_CLEAR 12
`define SPS_R6_MIRROR 11
`define SPS_R6_GLITCH 10
`define SPS_R6_RATE 9
`define SPS_LAST_ENTRY 4'h8

`define SPS_SYNC_RST 5'h0A
`define SPS_CLK_HZ 25000000
`define SPS_CLK_NS 40
`define SPS_PWM_SLOW_HZ 20000
`define SPS_PWM_FAST_HZ 30000
`define SPS_PWM_SLOW_CYC (`SPS_CLK_HZ / `SPS_PWM_SLOW_HZ)
`define SPS_PWM_FAST_CYC (`SPS_CLK_HZ / `SPS_PWM_FAST_HZ)
`define SPS_GLITCH_SHORT_NS 1500
`define SPS_GLITCH_LONG_NS 2500
`define SPS_GLITCH_SHORT_CYC \
    ((`SPS_GLITCH_SHORT_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)
`define SPS_GLITCH_LONG_CYC \
    ((`SPS_GLITCH_LONG_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)
`define SPS_STALL_UNIT_NS 1000
`define SPS_STALL_UNIT_CYC (`SPS_STALL_UNIT_NS / `SPS_CLK_NS)

`endif

// file: design/sps_pkg.sv
package sps_pkg;

    typedef enum logic [1:0] {
        SPS_IDLE = 2'b01,
        SPS_FRAME = 2'b10
    } sps_state_t;

    typedef struct packed {
        logic keep_outputs;
        logic [1:0] factory_test_bits;
        logic pwm_pin_disable;
        logic pin_mirrors_block_flag;
        logic glitch_window_sel;
        logic pwm_rate_sel;
        logic [2:0] full_scale_sel;
        logic [7:0] stall_threshold;
    } sps_cfg_t;

    typedef struct packed {
        logic motor_blocked_flag;
        logic ref_current_fault;
        logic open_load_b;
        logic open_load_a;
    } sps_flags_t;

endpackage

// file: design/sps_prof_mem.sv
`timescale 1ns/1ps
`default_nettype none
module sps_prof_mem #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 5,
    parameter int AW = 3
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr_a,
    output logic [WIDTH-1:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [WIDTH-1:0] rdata_b
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    mem_q[gi] <= '0;
                end else if (we && waddr == AW'(gi)) begin
                    mem_q[gi] <= wdata;
                end
            end
        end
    endgenerate

    // Out of range reads return zero so unused words stay quiet
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata_a <= '0;
            rdata_b <= '0;
        end else begin
            rdata_a <= (32'(raddr_a) < DEPTH) ? mem_q[raddr_a] : '0;
            rdata_b <= (32'(raddr_b) < DEPTH) ? mem_q[raddr_b] : '0;
        end
    end
endmodule
`default_nettype wire

// file: design/sps_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "sps_cfg.svh"
module sps_regs import sps_pkg::*; (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic spi_clk,
    input wire logic select_low_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic step_req,
    input wire logic step_to_b,
    input wire logic [3:0] step_index,
    input wire logic pwm_a_ctrl,
    input wire logic quadrant_end,
    input wire logic open_load_a_evt,
    input wire logic open_load_b_evt,
    input wire logic ref_current_ok,
    input wire logic supply_overvolt,
    input wire logic status7_fault,
    input wire logic bridge_hiz_clear,
    output logic [4:0] bridge_a_level,
    output logic [4:0] bridge_b_level,
    output logic [2:0] full_scale_sel,
    output logic bridges_hiz,
    output logic supply_high_set,
    output logic pwm_pin,
    output logic pwm_pin_oe,
    output logic [10:0] pwm_period_cyc,
    output logic [6:0] glitch_cyc
);
    // Pin synchronisers: first stage read only by the second
    logic [4:0] sy1_q, sy2_q;
    logic sclk_d_q, csn_d_q, ov_d_q;
    logic sclk_s, csn_s, sdi_s, ref_ok_s, ov_s;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, ov_rise;

    sps_state_t state_q;
    logic [4:0] cnt_q;
    logic [15:0] in_sh_q, out_sh_q;
    logic [2:0] last_addr_q;
    logic loaded_q, shown_q;
    logic commit, clear6, fault_lvl;
    logic [2:0] wr_addr;
    logic [12:0] wr_data, rd_word;

    sps_cfg_t cfg_q;
    sps_flags_t flags_q;
    logic [9:0] mem_rd_a, mem_rd_b;
    logic mem_we;
    logic [2:0] mem_waddr;
    logic [9:0] mem_wdata;
    logic pend_q, pend_b_q, pend_half_q;
    logic [4:0] entry;
    logic [4:0] tick_q;
    logic [7:0] sum_q;
    logic stall_hit;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sy1_q <= `SPS_SYNC_RST;
            sy2_q <= `SPS_SYNC_RST;
        end else begin
            sy1_q <= {supply_overvolt, ref_current_ok, serial_in,
                      select_low_n, spi_clk};
            sy2_q <= sy1_q;
        end
    end

    assign sclk_s = sy2_q[0];
    assign csn_s = sy2_q[1];
    assign sdi_s = sy2_q[2];
    assign ref_ok_s = sy2_q[3];
    assign ov_s = sy2_q[4];

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sclk_d_q <= 1'b0;
            csn_d_q <= 1'b1;
            ov_d_q <= 1'b0;
        end else begin
            sclk_d_q <= sclk_s;
            csn_d_q <= csn_s;
            ov_d_q <= ov_s;
        end
    end

    assign sclk_rise = sclk_s && !sclk_d_q;
    assign sclk_fall = !sclk_s && sclk_d_q;
    assign cs_fall = !csn_s && csn_d_q;
    assign cs_rise = csn_s && !csn_d_q;
    assign ov_rise = ov_s && !ov_d_q;

    // Frame capture; the count saturates so long frames never wrap to 16
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_q <= SPS_IDLE;
            cnt_q <= 5'h00;
            in_sh_q <= 16'h0000;
        end else begin
            unique case (state_q)
                SPS_IDLE: begin
                    if (cs_fall) begin
                        state_q <= SPS_FRAME;
                        cnt_q <= 5'h00;
                    end
                end
                SPS_FRAME: begin
                    if (cs_rise) begin
                        state_q <= SPS_IDLE;
                    end else if (sclk_rise) begin
                        in_sh_q <= {in_sh_q[14:0], sdi_s};
                        if (cnt_q != `SPS_CNT_SAT) begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                end
            endcase
        end
    end

    assign commit = (state_q == SPS_FRAME) && cs_rise
                    && (cnt_q == `SPS_FRAME_BITS);
    assign wr_addr = in_sh_q[`SPS_ADDR_MSB:`SPS_ADDR_LSB];
    assign wr_data = in_sh_q[12:0];
    assign clear6 = commit && wr_addr == `SPS_REG_PROF8
                    && wr_data[`SPS_R6_CLEAR];

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            last_addr_q <= 3'h0;
        end else if (commit) begin
            last_addr_q <= wr_addr;
        end
    end

    // Control fields; test bits stored as written, host keeps them zero
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cfg_q <= '0;
        end else if (commit) begin
            unique case (wr_addr)
                `SPS_REG_LEVELS:
                    cfg_q.full_scale_sel <=
                        wr_data[`SPS_FS_MSB:`SPS_FS_LSB];
                `SPS_REG_PROF01: begin
                    cfg_q.keep_outputs <= wr_data[`SPS_R2_KEEP];
                    cfg_q.factory_test_bits <=
                        wr_data[`SPS_R2_TEST_MSB:`SPS_R2_TEST_LSB];
                end
                `SPS_REG_PROF23: begin
                    cfg_q.pwm_pin_disable <= wr_data[`SPS_R3_PWMDIS];
                    cfg_q.stall_threshold[1:0] <=
                        wr_data[`SPS_R3_THR_MSB:`SPS_R3_THR_LSB];
                end
                `SPS_REG_PROF45:
                    cfg_q.stall_threshold[4:2] <=
                        wr_data[`SPS_R45_THR_MSB:`SPS_R45_THR_LSB];
                `SPS_REG_PROF67:
                    cfg_q.stall_threshold[7:5] <=
                        wr_data[`SPS_R45_THR_MSB:`SPS_R45_THR_LSB];
                `SPS_REG_PROF8: begin
                    cfg_q.pin_mirrors_block_flag <= wr_data[`SPS_R6_MIRROR];
                    cfg_q.glitch_window_sel <= wr_data[`SPS_R6_GLITCH];
                    cfg_q.pwm_rate_sel <= wr_data[`SPS_R6_RATE];
                end
                default: begin
                end
            endcase
        end
    end

    // Profile table: word n holds entries 2n and 2n+1, except word 4, which holds entry 8 only
    assign mem_we = commit && wr_addr >= `SPS_REG_PROF01
                    && wr_addr <= `SPS_REG_PROF8;
    assign mem_waddr = wr_addr - `SPS_REG_PROF01;
    assign mem_wdata = (wr_addr == `SPS_REG_PROF8)
        ? {5'h00, wr_data[`SPS_LO_MSB:`SPS_LO_LSB]}
        : {wr_data[`SPS_HI_MSB:`SPS_HI_LSB],
           wr_data[`SPS_LO_MSB:`SPS_LO_LSB]};

    sps_prof_mem #(
        .WIDTH(10),
        .DEPTH(5),
        .AW(3)
    ) u_mem (
        .core_clk(core_clk),
        .rstn(rstn),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr_a(step_index[3:1]),
        .rdata_a(mem_rd_a),
        .raddr_b(last_addr_q - `SPS_REG_PROF01),
        .rdata_b(mem_rd_b)
    );

    // Level copy takes two cycles because the table read is registered
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pend_q <= 1'b0;
            pend_b_q <= 1'b0;
            pend_half_q <= 1'b0;
        end else begin
            pend_q <= step_req && step_index <= `SPS_LAST_ENTRY;
            pend_b_q <= step_to_b;
            pend_half_q <= step_index[0];
        end
    end

    assign entry = pend_half_q ? mem_rd_a[9:5] : mem_rd_a[4:0];

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            bridge_a_level <= 5'h00;
            bridge_b_level <= 5'h00;
        end else if (pend_q) begin
            if (pend_b_q) begin
                bridge_b_level <= entry;
            end else begin
                bridge_a_level <= entry;
            end
        end
    end

    // Rise-time sum in unit ticks, saturating at the threshold width
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tick_q <= 5'h00;
            sum_q <= 8'h00;
        end else if (quadrant_end) begin
            tick_q <= 5'h00;
            sum_q <= 8'h00;
        end else if (pwm_a_ctrl) begin
            if (tick_q == 5'(`SPS_STALL_UNIT_CYC - 1)) begin
                tick_q <= 5'h00;
                if (sum_q != 8'hFF) begin
                    sum_q <= sum_q + 8'h01;
                end
            end else begin
                tick_q <= tick_q + 5'h01;
            end
        end
    end

    assign stall_hit = quadrant_end
                       && (sum_q < cfg_q.stall_threshold);

    // Sticky flags; a cause present during the clear wins
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            flags_q <= '0;
        end else begin
            flags_q.open_load_a <= (flags_q.open_load_a && !clear6)
                                   || open_load_a_evt;
            flags_q.open_load_b <= (flags_q.open_load_b && !clear6)
                                   || open_load_b_evt;
            flags_q.ref_current_fault <= (flags_q.ref_current_fault
                                   && !clear6) || !ref_ok_s;
            flags_q.motor_blocked_flag <= (flags_q.motor_blocked_flag
                                   && !clear6) || stall_hit;
        end
    end

    // Overvoltage reaction
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            bridges_hiz <= 1'b0;
            supply_high_set <= 1'b0;
        end else begin
            supply_high_set <= ov_rise;
            if (ov_rise && !cfg_q.keep_outputs) begin
                bridges_hiz <= 1'b1;
            end else if (bridge_hiz_clear) begin
                bridges_hiz <= 1'b0;
            end
        end
    end

    // Pin and power-stage settings
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pwm_pin <= 1'b0;
            pwm_pin_oe <= 1'b0;
            pwm_period_cyc <= 11'(`SPS_PWM_FAST_CYC);
            glitch_cyc <= 7'(`SPS_GLITCH_SHORT_CYC);
            full_scale_sel <= 3'h0;
        end else begin
            pwm_pin <= cfg_q.pin_mirrors_block_flag
                       ? flags_q.motor_blocked_flag : pwm_a_ctrl;
            pwm_pin_oe <= !cfg_q.pwm_pin_disable;
            pwm_period_cyc <= cfg_q.pwm_rate_sel
                ? 11'(`SPS_PWM_SLOW_CYC) : 11'(`SPS_PWM_FAST_CYC);
            glitch_cyc <= cfg_q.glitch_window_sel
                ? 7'(`SPS_GLITCH_LONG_CYC)
                : 7'(`SPS_GLITCH_SHORT_CYC);
            full_scale_sel <= cfg_q.full_scale_sel;
        end
    end

    // Read-back of the register picked by the last committed frame
    always_comb begin
        unique case (last_addr_q)
            `SPS_REG_LEVELS:
                rd_word = {cfg_q.full_scale_sel, bridge_b_level,
                           bridge_a_level};
            `SPS_REG_PROF01:
                rd_word = {mem_rd_b[9:5], cfg_q.keep_outputs,
                           cfg_q.factory_test_bits, mem_rd_b[4:0]};
            `SPS_REG_PROF23:
                rd_word = {mem_rd_b[9:5], cfg_q.stall_threshold[1:0],
                           cfg_q.pwm_pin_disable, mem_rd_b[4:0]};
            `SPS_REG_PROF45:
                rd_word = {mem_rd_b[9:5], cfg_q.stall_threshold[4:2],
                           mem_rd_b[4:0]};
            `SPS_REG_PROF67:
                rd_word = {mem_rd_b[9:5], cfg_q.stall_threshold[7:5],
                           mem_rd_b[4:0]};
            `SPS_REG_PROF8:
                rd_word = {1'b0, cfg_q.pin_mirrors_block_flag,
                           cfg_q.glitch_window_sel, cfg_q.pwm_rate_sel,
                           flags_q, mem_rd_b[4:0]};
            default:
                rd_word = 13'h0000;
        endcase
    end

    assign fault_lvl = flags_q.open_load_a || flags_q.open_load_b
                       || flags_q.ref_current_fault || status7_fault;

    // Fault level shows until the first falling clock after the load
    always_ff @(posedge core_clk) begin
        if (!rstn || state_q == SPS_IDLE) begin
            out_sh_q <= 16'h0000;
            loaded_q <= 1'b0;
            shown_q <= 1'b0;
        end else if (sclk_rise && !loaded_q) begin
            out_sh_q <= {last_addr_q, rd_word};
            loaded_q <= 1'b1;
        end else if (sclk_fall && loaded_q) begin
            if (shown_q) begin
                out_sh_q <= {out_sh_q[14:0], 1'b0};
            end
            shown_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            serial_out <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out_oe <= (state_q == SPS_FRAME);
            serial_out <= (state_q == SPS_FRAME)
                          && (shown_q ? out_sh_q[15] : fault_lvl);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_ov_trip;
        ov_rise && !cfg_q.keep_outputs;
    endsequence

    sequence s_bad_frame_end;
        state_q == SPS_FRAME && cs_rise && cnt_q != `SPS_FRAME_BITS;
    endsequence

    a_bad_frame_drop: assert property (
        s_bad_frame_end |=> $stable(cfg_q) && $stable(last_addr_q))
        else $error("frame without 16 clocks changed a register");
    a_full_scale_wr: assert property (
        commit && wr_addr == `SPS_REG_LEVELS |-> ##2
        full_scale_sel == $past(wr_data[12:10], 2))
        else $error("full scale field not taken from frame");
    a_level_copy: assert property (
        pend_q && !pend_b_q |=> bridge_a_level == $past(entry))
        else $error("bridge A level not loaded from profile");
    a_ov_float: assert property (
        s_ov_trip |=> bridges_hiz && supply_high_set)
        else $error("overvoltage did not float bridges");
    a_ov_keep: assert property (
        ov_rise && cfg_q.keep_outputs && !bridges_hiz |=>
        !bridges_hiz && supply_high_set)
        else $error("overvoltage changed bridges in keep mode");
    a_pin_float: assert property (
        cfg_q.pwm_pin_disable [*2] |-> !pwm_pin_oe)
        else $error("PWM pin driven while disabled");
    a_pin_mirror: assert property (
        cfg_q.pin_mirrors_block_flag |=>
        pwm_pin == $past(flags_q.motor_blocked_flag))
        else $error("PWM pin does not mirror blocked flag");
    a_stall_set: assert property (
        quadrant_end && sum_q < cfg_q.stall_threshold |=>
        flags_q.motor_blocked_flag)
        else $error("short quadrant did not flag a stall");
    a_flags_clear: assert property (
        clear6 && !open_load_a_evt && !open_load_b_evt && ref_ok_s
        && !stall_hit |=> flags_q == '0)
        else $error("clear left a flag set");
    a_rate_sel: assert property (
        cfg_q.pwm_rate_sel |=> pwm_period_cyc == 11'(`SPS_PWM_SLOW_CYC))
        else $error("PWM period does not follow rate select");
    a_fault_show: assert property (
        state_q == SPS_FRAME && !shown_q |=> serial_out == $past(fault_lvl))
        else $error("serial out does not show fault level");
endmodule
`default_nettype wire

// file: test/sps_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module sps_spi_host (
    input wire logic core_clk,
    output logic spi_clk,
    output logic select_low_n,
    output logic serial_in,
    input wire logic serial_out
);
    // Idle levels follow the pin pulls: select up, clock and data down
    initial begin
        spi_clk = 1'b0;
        select_low_n = 1'b1;
        serial_in = 1'b0;
    end

    // Half period of 6 core cycles leaves margin over the 3-cycle sync delay
    task automatic xfer(input logic [15:0] w, input int n, output logic f,
        output logic [15:0] rd);
        rd = 16'h0000;
        @(posedge core_clk) select_low_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        f = serial_out;
        for (int i = 0; i < n; i++) begin
            serial_in <= w[15 - (i % 16)];
            repeat (6) @(posedge core_clk);
            if (i >= 1 && i < 16) rd[16 - i] = serial_out;
            spi_clk <= 1'b1;
            repeat (6) @(posedge core_clk);
            spi_clk <= 1'b0;
        end
        repeat (6) @(posedge core_clk);
        select_low_n <= 1'b1;
        serial_in <= 1'b0;
        repeat (10) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sps_cfg.svh"
module tb_top;
    logic core_clk, rstn, step_req, step_to_b, pwm_a, quad, ol_a, ol_b;
    logic ref_ok, ov, hiz_clr, spi_clk, sel_n, sdi, sdo, sdo_oe, hiz, ovset;
    logic pin, pin_oe, flt, s7;
    logic [3:0] step_index;
    logic [4:0] lvl_a, lvl_b;
    logic [2:0] fs;
    logic [10:0] per;
    logic [6:0] glt;
    logic [15:0] rdw;
    int num_errors = 0;
    int checks = 0;

    sps_regs sps_regs_inst (.core_clk(core_clk), .rstn(rstn),
        .spi_clk(spi_clk), .select_low_n(sel_n), .serial_in(sdi),
        .serial_out(sdo), .serial_out_oe(sdo_oe), .step_req(step_req),
        .step_to_b(step_to_b), .step_index(step_index), .pwm_a_ctrl(pwm_a),
        .quadrant_end(quad), .open_load_a_evt(ol_a), .open_load_b_evt(ol_b),
        .ref_current_ok(ref_ok), .supply_overvolt(ov), .status7_fault(s7),
        .bridge_hiz_clear(hiz_clr), .bridge_a_level(lvl_a),
        .bridge_b_level(lvl_b), .full_scale_sel(fs), .bridges_hiz(hiz),
        .supply_high_set(ovset), .pwm_pin(pin), .pwm_pin_oe(pin_oe),
        .pwm_period_cyc(per), .glitch_cyc(glt));
    sps_spi_host sps_spi_host_inst (.core_clk(core_clk), .spi_clk(spi_clk),
        .select_low_n(sel_n), .serial_in(sdi), .serial_out(sdo));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic test_done();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic frame(input logic [2:0] a, input logic [12:0] d,
        input int n);
        sps_spi_host_inst.xfer({a, d}, n, flt, rdw);
        tick(1);
    endtask

    task automatic step(input logic [3:0] idx, input logic b);
        @(posedge core_clk);
        step_req <= 1'b1;
        step_index <= idx;
        step_to_b <= b;
        @(posedge core_clk) step_req <= 1'b0;
        tick(2);
    endtask

    // Sub-unit remainders may carry, so counts stay clear of unit edges
    task automatic quadrant(input int n);
        @(posedge core_clk) pwm_a <= 1'b1;
        repeat (n) @(posedge core_clk);
        pwm_a <= 1'b0;
        quad <= 1'b1;
        @(posedge core_clk) quad <= 1'b0;
        tick(3);
    endtask

    task automatic ov_event(input logic keep);
        int n;
        n = 0;
        frame(3'h2, {5'h0A, keep, 2'b00, 5'h15}, 16);
        @(posedge core_clk) ov <= 1'b1;
        repeat (8) begin
            tick(1);
            if (ovset === 1'b1) n++;
        end
        check(16'(n), 16'h1);
        check(hiz, !keep);
        @(posedge core_clk) ov <= 1'b0;
        hiz_clr <= 1'b1;
        @(posedge core_clk) hiz_clr <= 1'b0;
        tick(2);
        check(hiz, 1'b0);
    endtask

    task automatic t_fault(input int c);
        @(posedge core_clk);
        ol_a <= (c == 0);
        ol_b <= (c == 1);
        ref_ok <= (c != 2);
        @(posedge core_clk);
        ol_a <= 1'b0;
        ol_b <= 1'b0;
        tick(4);
        frame(3'h0, 13'h0, 16);
        check(flt, 1'b1);
        frame(3'h6, 13'h1000, 16);
        frame(3'h0, 13'h0, 16);
        check(flt, c == 2);
        @(posedge core_clk) ref_ok <= 1'b1;
        tick(4);
        frame(3'h6, 13'h1000, 16);
        frame(3'h0, 13'h0, 16);
        check(flt, 1'b0);
    endtask

    initial begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        test_done();
    end

    initial begin
        {rstn, step_req, step_to_b, pwm_a, quad, ol_a, ol_b} = 7'h00;
        {ov, hiz_clr, step_index} = 6'h00;
        s7 = 1'b0;
        ref_ok = 1'b1;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        tick(4);
        check(per, 16'(`SPS_PWM_FAST_CYC));
        check(glt, 16'(`SPS_GLITCH_SHORT_CYC));
        check({fs, lvl_a, lvl_b}, 13'h0);
        check({pin_oe, sdo_oe, hiz}, 3'b100);
        frame(3'h1, 13'h17FF, 15);
        check(fs, 3'h0);
        frame(3'h1, 13'h17FF, 17);
        check(fs, 3'h0);
        frame(3'h1, 13'h17FF, 16);
        tick(1);
        check(fs, 3'h5);
        check({lvl_a, lvl_b}, 10'h0);
        frame(3'h2, 13'h0A15, 16);
        frame(3'h6, 13'h061B, 16);
        check(per, 16'(`SPS_PWM_SLOW_CYC));
        check(glt, 16'(`SPS_GLITCH_LONG_CYC));
        step(4'h0, 1'b0);
        check(lvl_a, 5'h15);
        step(4'h1, 1'b1);
        check(lvl_b, 5'h0A);
        step(4'h8, 1'b0);
        check(lvl_a, 5'h1B);
        step(4'h9, 1'b1);
        check(lvl_b, 5'h0A);
        frame(3'h0, 13'h0, 16);
        check(rdw & 16'hFFFC, 16'hC618);
        @(posedge core_clk) pwm_a <= 1'b1;
        tick(2);
        check({pin_oe, pin}, 2'b11);
        @(posedge core_clk) pwm_a <= 1'b0;
        tick(2);
        check(pin, 1'b0);
        frame(3'h3, 13'h0020, 16);
        check(pin_oe, 1'b0);
        frame(3'h3, 13'h00C0, 16);
        check(rdw & 16'hFFFC, 16'h6020);
        frame(3'h6, 13'h0800, 16);
        quadrant(80);
        check(pin, 1'b0);
        quadrant(40);
        check(pin, 1'b1);
        frame(3'h6, 13'h1800, 16);
        check(pin, 1'b0);
        ov_event(1'b0);
        ov_event(1'b1);
        for (int c = 0; c < 3; c++) t_fault(c);
        @(posedge core_clk) s7 <= 1'b1;
        frame(3'h0, 13'h0, 16);
        check(flt, 1'b1);
        @(posedge core_clk) s7 <= 1'b0;
        tick(2);
        frame(3'h0, 13'h0, 16);
        check(flt, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
